/* File: eprom_program_verify_port_bench.sv */
// Top testbench for the EPROM program/verify port
`timescale 1ns/1ps
`default_nettype none
module eprom_program_verify_port_bench;
  logic       sys_clk;
  logic       reset;
  logic       eraseRequest;
  logic       resetPin;
  logic       programStoreEnableN;
  logic       latchProgramStrobeN;
  logic       externalAccessProgramSupply;
  logic       supplyAtProgramVoltage;
  logic [7:0] portOneIn;
  logic [7:0] portTwoIn;
  logic [7:0] portThreeIn;
  logic [7:0] programDataBusIn;
  logic [7:0] programDataBusOut;
  logic       programDataBusOeN;
  logic       programInhibit;
  logic       verifyInhibit;
  logic       externalExecInhibit;
  logic [7:0] code [256];
  logic [7:0] enc [64];
  logic [2:0] locks;
  int         badCount;
  int         testsRun;
  epv_program_port #(.CODE_DEPTH(256)) epv_program_port_inst (.*);
  epv_programmer epv_programmer_inst (.*);
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  function automatic logic [7:0] expVerify(input logic [13:0] a);
    return ~(code[a[7:0]] ^ enc[a[5:0]]);
  endfunction
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    testsRun++;
    if (got !== exp) begin
      badCount++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic finishTest;
    $display("checks=%0d mismatches=%0d", testsRun, badCount);
    if (badCount == 0 && testsRun > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic blank;
    foreach (code[i]) code[i] = 8'hFF;
    foreach (enc[i]) enc[i] = 8'hFF;
    locks = 3'h0;
  endtask
  task automatic wrCode(input logic [13:0] a, input logic [7:0] d);
    epv_programmer_inst.prog(a, d, epv_pkg::SEL_CODE_WRITE, 5);
    if (!locks[0]) code[a[7:0]] &= d;
  endtask
  task automatic verify(input logic [13:0] a);
    logic [7:0] q;
    logic       o;
    epv_programmer_inst.read(a, epv_pkg::SEL_VERIFY, q, o);
    check({7'h0, o}, {7'h0, locks[0] & locks[1]});
    if (!(locks[0] && locks[1])) check(q, expVerify(a));
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    badCount++;
    finishTest();
  end
  initial begin
    logic [13:0] a;
    logic [7:0]  q;
    logic        o;
    logic [4:0]  lockSel [3];
    logic [13:0] sigAdr [4];
    logic [7:0]  sigVal [4];
    lockSel = '{epv_pkg::SEL_LOCK1, epv_pkg::SEL_LOCK2, epv_pkg::SEL_LOCK3};
    sigAdr = '{14'h0030, 14'h0031, 14'h0060, 14'h0061};
    sigVal = '{8'hA5, 8'h3C, 8'h5A, 8'hFF};
    reset = 1'b1;
    eraseRequest = 1'b0;
    void'($urandom(57296));
    blank();
    epv_programmer_inst.tick(2);
    reset = 1'b0;
    for (int i = 0; i < 4; i++) begin
      epv_programmer_inst.read(sigAdr[i], epv_pkg::SEL_SIGNATURE, q, o);
      check(q, sigVal[i]);
    end
    for (int i = 0; i < 8; i++) begin
      a = (i < 2) ? 14'(i * 255) : 14'($urandom_range(255));
      wrCode(a, 8'($urandom));
      verify(a);
    end
    wrCode(a, 8'h0F);
    verify(a);
    q = 8'($urandom);
    a = 14'($urandom_range(63));
    epv_programmer_inst.prog(a, q, epv_pkg::SEL_ENC_WRITE, 25);
    enc[a[5:0]] &= q;
    epv_programmer_inst.prog(a | 14'h40, 8'h00, epv_pkg::SEL_ENC_WRITE, 25);
    epv_programmer_inst.prog(a, 8'h00, 5'h1A, 5);
    verify(a);
    verify(a | 14'h0080);
    epv_programmer_inst.read(a, 5'h1A, q, o);
    check({7'h0, o}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      epv_programmer_inst.prog(a, 8'h00, lockSel[i], 25);
      locks[i] = 1'b1;
      q = {5'h0, externalExecInhibit, verifyInhibit, programInhibit};
      check(q, {5'h0, locks});
      wrCode(a ^ 14'h0001, 8'h00);
      verify(a ^ 14'h0001);
    end
    eraseRequest = 1'b1;
    epv_programmer_inst.tick(8);
    eraseRequest = 1'b0;
    blank();
    epv_programmer_inst.tick(4);
    q = {5'h0, externalExecInhibit, verifyInhibit, programInhibit};
    check(q, 8'h00);
    verify(a);
    finishTest();
  end
endmodule
bind epv_program_port epv_props #(.SIG_BYTE_0(SIG_BYTE_0)) epv_props_inst (.*);
`default_nettype wire

/* File: epv_pkg.sv */
// Constants and types for the program/verify port of the on-chip EPROM
package epv_pkg;

  localparam int ADDR_W     = 14;
  localparam int DATA_W     = 8;
  localparam int ENC_DEPTH  = 64;
  localparam int ENC_IDX_W  = 6;
  localparam int SYNC_W     = 38;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Selector order: {modeSelectA, modeSelectB, modeSelectC,
  //                  modeSelectD, modeSelectE}
  localparam logic [4:0] SEL_CODE_WRITE = 5'h0F;
  localparam logic [4:0] SEL_ENC_WRITE  = 5'h0D;
  localparam logic [4:0] SEL_LOCK1      = 5'h1F;
  localparam logic [4:0] SEL_LOCK2      = 5'h1C;
  localparam logic [4:0] SEL_LOCK3      = 5'h16;
  localparam logic [4:0] SEL_VERIFY     = 5'h03;
  localparam logic [4:0] SEL_SIGNATURE  = 5'h00;

  // Pin positions of the selector and the address bits on the ports
  localparam int P2_SEL_A  = 6;
  localparam int P2_SEL_B  = 7;
  localparam int P3_SEL_C  = 3;
  localparam int P3_SEL_D  = 6;
  localparam int P3_SEL_E  = 7;
  localparam int P2_ADDR_W = 6;
  localparam int P3_ADDR_LO = 4;
  localparam int P3_ADDR_HI = 5;

  localparam logic [13:0] SIG_ADDR_0 = 14'h0030;
  localparam logic [13:0] SIG_ADDR_1 = 14'h0031;
  localparam logic [13:0] SIG_ADDR_2 = 14'h0060;

  typedef enum logic [2:0] {
    EPV_IDLE,
    EPV_CODE_WRITE,
    EPV_ENC_WRITE,
    EPV_LOCK_WRITE,
    EPV_VERIFY,
    EPV_SIGNATURE
  } epv_mode_t;

endpackage

/* File: epv_program_port.sv */
// Program and verify port of the on-chip EPROM, with lock and encryption
// How it works
// - Address from port one and port two low six bits
// - Write modes need strobe, program voltage, selector
// - Read modes: verify or signature by selector
// - Lock bits never read back directly
// - Three lock bits give rising protection
// - Erase clears encryption array and lock bits
// - Sixty-four encryption bytes start all ones
// - Six address bits pick the encryption byte
// - Verify byte is code XNOR encryption byte
// - Three signature bytes at fixed locations
`timescale 1ns/1ps
`default_nettype none
module epv_program_port #(
  parameter int         CODE_DEPTH = 16384,
  parameter logic [7:0] SIG_BYTE_0 = 8'hA5,  // Arbitrary value
  parameter logic [7:0] SIG_BYTE_1 = 8'h3C,  // Arbitrary value
  parameter logic [7:0] SIG_BYTE_2 = 8'h5A   // Arbitrary value
) (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       resetPin,
  input  wire logic       programStoreEnableN,
  input  wire logic       latchProgramStrobeN,
  input  wire logic       externalAccessProgramSupply,
  input  wire logic       supplyAtProgramVoltage,
  input  wire logic [7:0] portOneIn,
  input  wire logic [7:0] portTwoIn,
  input  wire logic [7:0] portThreeIn,
  input  wire logic [7:0] programDataBusIn,
  input  wire logic       eraseRequest,
  output logic      [7:0] programDataBusOut,
  output logic            programDataBusOeN,
  output logic            programInhibit,
  output logic            verifyInhibit,
  output logic            externalExecInhibit
);

  typedef struct packed {
    logic [CODE_DEPTH-1:0][7:0]       codeArray;
    logic [epv_pkg::ENC_DEPTH-1:0][7:0] encArray;
    logic [2:0]                       lockBits;
    logic                             strobePrev;
    logic [7:0]                       dataOut;
    logic                             dataOeN;
  } epv_state_t;

  epv_state_t state;
  epv_state_t next_state;

  logic [epv_pkg::SYNC_W-1:0] pinsRaw;
  logic [epv_pkg::SYNC_W-1:0] pinsSync;

  logic       rstLevel;
  logic       psenN;
  logic       strobeN;
  logic       supplyHigh;
  logic       supplyVpp;
  logic       eraseLevel;
  logic [7:0] p1;
  logic [7:0] p2;
  logic [7:0] p3;
  logic [7:0] dataIn;

  logic [15:0]                   pinAddress;
  logic [epv_pkg::ADDR_W-1:0]    programAddressBits;
  logic [4:0]                    modeSelect;
  logic [epv_pkg::ENC_IDX_W-1:0] encIndex;
  epv_pkg::epv_mode_t            mode;
  logic                          strobeFall;
  logic                          writeWindow;
  logic                          readWindow;
  logic                          addrInArray;
  logic [7:0]                    codeByte;
  logic [7:0]                    encByte;
  logic [7:0]                    sigByte;

  // Every pin is asynchronous to sys_clk, so all pass two flops
  assign pinsRaw = {resetPin, programStoreEnableN, latchProgramStrobeN,
                    externalAccessProgramSupply, supplyAtProgramVoltage,
                    eraseRequest, portOneIn, portTwoIn, portThreeIn,
                    programDataBusIn};

  epv_sync #(
    .WIDTH (epv_pkg::SYNC_W)
  ) u_pin_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .asyncIn (pinsRaw),
    .syncOut (pinsSync)
  );

  assign {rstLevel, psenN, strobeN, supplyHigh, supplyVpp, eraseLevel,
          p1, p2, p3, dataIn} = pinsSync;

  // Address A0 upward: port one, port two low six, port three bits 4-5
  assign pinAddress = {p3[epv_pkg::P3_ADDR_HI],
                       p3[epv_pkg::P3_ADDR_LO],
                       p2[epv_pkg::P2_ADDR_W-1:0],
                       p1};
  // Port-three bits land above A13, so the 14-bit space drops them
  assign programAddressBits = pinAddress[epv_pkg::ADDR_W-1:0];

  assign modeSelect = {p2[epv_pkg::P2_SEL_A], p2[epv_pkg::P2_SEL_B],
                       p3[epv_pkg::P3_SEL_C], p3[epv_pkg::P3_SEL_D],
                       p3[epv_pkg::P3_SEL_E]};

  assign encIndex    = programAddressBits[epv_pkg::ENC_IDX_W-1:0];
  assign addrInArray = 32'(programAddressBits) < CODE_DEPTH;
  assign codeByte    = addrInArray ? state.codeArray[programAddressBits]
                                   : epv_pkg::ERASED_BYTE;
  assign encByte     = state.encArray[encIndex];

  // Both write and read modes need the part held in reset and
  // the program-store enable low
  assign writeWindow = rstLevel && !psenN && supplyVpp;
  assign readWindow  = rstLevel && !psenN && !supplyVpp &&
                       supplyHigh && strobeN;

  // Programming happens on the falling edge of the strobe
  assign strobeFall = state.strobePrev && !strobeN;

  always_comb begin
    mode = epv_pkg::EPV_IDLE;
    case (modeSelect)
      epv_pkg::SEL_CODE_WRITE: begin
        if (writeWindow) mode = epv_pkg::EPV_CODE_WRITE;
      end
      epv_pkg::SEL_ENC_WRITE: begin
        if (writeWindow) mode = epv_pkg::EPV_ENC_WRITE;
      end
      epv_pkg::SEL_LOCK1, epv_pkg::SEL_LOCK2, epv_pkg::SEL_LOCK3: begin
        if (writeWindow) mode = epv_pkg::EPV_LOCK_WRITE;
      end
      epv_pkg::SEL_VERIFY: begin
        if (readWindow) mode = epv_pkg::EPV_VERIFY;
      end
      epv_pkg::SEL_SIGNATURE: begin
        if (readWindow) mode = epv_pkg::EPV_SIGNATURE;
      end
      default: begin
        mode = epv_pkg::EPV_IDLE;
      end
    endcase
  end

  always_comb begin
    case (programAddressBits)
      epv_pkg::SIG_ADDR_0: sigByte = SIG_BYTE_0;
      epv_pkg::SIG_ADDR_1: sigByte = SIG_BYTE_1;
      epv_pkg::SIG_ADDR_2: sigByte = SIG_BYTE_2;
      default:             sigByte = epv_pkg::ERASED_BYTE;
    endcase
  end

  always_comb begin
    next_state            = state;
    next_state.strobePrev = strobeN;
    next_state.dataOut    = epv_pkg::ERASED_BYTE;
    next_state.dataOeN    = 1'b1;

    // Each pulse only clears array bits or sets a lock bit, so repeated pulses on one location
    // are harmless and the pulse count is left to the programmer
    if (strobeFall) begin
      case (mode)
        epv_pkg::EPV_CODE_WRITE: begin
          if (!state.lockBits[0] && addrInArray) begin
            next_state.codeArray[programAddressBits] =
              codeByte & dataIn;
          end
        end
        epv_pkg::EPV_ENC_WRITE: begin
          // Only addresses 0-3FH reach the encryption array
          if (!state.lockBits[0] &&
              programAddressBits[epv_pkg::ADDR_W-1:epv_pkg::ENC_IDX_W]
                == '0) begin
            next_state.encArray[encIndex] = encByte & dataIn;
          end
        end
        epv_pkg::EPV_LOCK_WRITE: begin
          case (modeSelect)
            epv_pkg::SEL_LOCK1: next_state.lockBits[0] = 1'b1;
            epv_pkg::SEL_LOCK2: next_state.lockBits[1] = 1'b1;
            epv_pkg::SEL_LOCK3: next_state.lockBits[2] = 1'b1;
            default:            next_state.lockBits    = state.lockBits;
          endcase
        end
        default: begin
          next_state.lockBits = state.lockBits;
        end
      endcase
    end

    // Lock bits have no read path; only their effects are visible
    case (mode)
      epv_pkg::EPV_VERIFY: begin
        if (!(state.lockBits[0] && state.lockBits[1])) begin
          next_state.dataOut = ~(codeByte ^ encByte);
          next_state.dataOeN = 1'b0;
        end
      end
      epv_pkg::EPV_SIGNATURE: begin
        next_state.dataOut = sigByte;
        next_state.dataOeN = 1'b0;
      end
      default: begin
        next_state.dataOeN = 1'b1;
      end
    endcase

    // Erase wins over any write in the same cycle
    if (eraseLevel) begin
      next_state.codeArray = {CODE_DEPTH{epv_pkg::ERASED_BYTE}};
      next_state.encArray  = {epv_pkg::ENC_DEPTH{epv_pkg::ERASED_BYTE}};
      next_state.lockBits  = 3'h0;
    end
  end

  // Reset models a blank part: arrays erased, locks open
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state.codeArray  <= {CODE_DEPTH{epv_pkg::ERASED_BYTE}};
      state.encArray   <= {epv_pkg::ENC_DEPTH{epv_pkg::ERASED_BYTE}};
      state.lockBits   <= 3'h0;
      // Low, so the zeroed synchroniser cannot fake a fall after reset
      state.strobePrev <= 1'b0;
      state.dataOut    <= epv_pkg::ERASED_BYTE;
      state.dataOeN    <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  assign programDataBusOut   = state.dataOut;
  assign programDataBusOeN   = state.dataOeN;
  assign programInhibit      = state.lockBits[0];
  assign verifyInhibit       = state.lockBits[0] && state.lockBits[1];
  assign externalExecInhibit = &state.lockBits;

endmodule
`default_nettype wire

/* File: epv_programmer.sv */
// Behavioural external programmer driving the port pins
`timescale 1ns/1ps
`default_nettype none
module epv_programmer (
  input  wire logic       sys_clk,
  input  wire logic       programDataBusOeN,
  input  wire logic [7:0] programDataBusOut,
  output logic            resetPin,
  output logic            programStoreEnableN,
  output logic            latchProgramStrobeN,
  output logic            externalAccessProgramSupply,
  output logic            supplyAtProgramVoltage,
  output logic      [7:0] portOneIn,
  output logic      [7:0] portTwoIn,
  output logic      [7:0] portThreeIn,
  output logic      [7:0] programDataBusIn
);
  logic       drv;
  logic [7:0] wd;
  // Released bus shows the inverse of the last byte, never a held value
  assign programDataBusIn = !programDataBusOeN ? programDataBusOut
                          : (drv ? wd : ~wd);
  initial begin
    {resetPin, programStoreEnableN} = 2'h2;
    {latchProgramStrobeN, externalAccessProgramSupply} = 2'h3;
    {supplyAtProgramVoltage, drv, wd} = 10'h000;
    {portOneIn, portTwoIn, portThreeIn} = 24'h000080;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic put(input logic [13:0] a, input logic [4:0] s);
    portOneIn = a[7:0];
    portTwoIn[5:0] = a[13:8];
    portThreeIn[5:4] = a[13:12];
    tick(3);
    {portTwoIn[6], portTwoIn[7], portThreeIn[3]} = s[4:2];
    {portThreeIn[6], portThreeIn[7]} = s[1:0];
  endtask
  task automatic prog(input logic [13:0] a, input logic [7:0] d,
                      input logic [4:0] s, input int n);
    wd = d;
    drv = 1'b1;
    put(a, s);
    tick(3);
    supplyAtProgramVoltage = 1'b1;
    tick(3);
    repeat (n) begin
      latchProgramStrobeN = 1'b0;
      tick(4);
      latchProgramStrobeN = 1'b1;
      tick(4);
    end
    supplyAtProgramVoltage = 1'b0;
    tick(3);
    drv = 1'b0;
    tick(1);
  endtask
  task automatic read(input logic [13:0] a, input logic [4:0] s,
                      output logic [7:0] q, output logic o);
    put(a, s);
    tick(4);
    q = programDataBusIn;
    o = programDataBusOeN;
  endtask
endmodule
`default_nettype wire

/* File: epv_props.sv */
// Checker for the EPROM program/verify port pins
`timescale 1ns/1ps
`default_nettype none
module epv_props #(
  parameter logic [7:0] SIG_BYTE_0 = 8'hA5
) (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       resetPin,
  input wire logic       programStoreEnableN,
  input wire logic       latchProgramStrobeN,
  input wire logic       externalAccessProgramSupply,
  input wire logic       supplyAtProgramVoltage,
  input wire logic [7:0] portOneIn,
  input wire logic [7:0] portTwoIn,
  input wire logic [7:0] portThreeIn,
  input wire logic [7:0] programDataBusIn,
  input wire logic       eraseRequest,
  input wire logic [7:0] programDataBusOut,
  input wire logic       programDataBusOeN,
  input wire logic       programInhibit,
  input wire logic       verifyInhibit,
  input wire logic       externalExecInhibit
);
  logic [4:0]  sel;
  logic [13:0] adr;
  logic        rdOk;
  assign sel = {portTwoIn[6], portTwoIn[7], portThreeIn[3],
                portThreeIn[6], portThreeIn[7]};
  assign adr = {portTwoIn[5:0], portOneIn};
  // Pins reach the outputs three edges later: two sync flops, one register
  assign rdOk = resetPin && !programStoreEnableN && latchProgramStrobeN
    && externalAccessProgramSupply && !supplyAtProgramVoltage
    && (sel == epv_pkg::SEL_VERIFY || sel == epv_pkg::SEL_SIGNATURE);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  rst_idle_a: assert property (
    $fell(reset) |-> programDataBusOeN) else $error("bus driven at reset");
  read_only_a: assert property (
    !programDataBusOeN |-> $past(rdOk, 3)) else $error("drive outside read");
  idle_ff_a: assert property (
    programDataBusOeN |-> programDataBusOut == 8'hFF) else $error("idle data");
  sig_byte_a: assert property (
    !programDataBusOeN && $past(sel, 3) == epv_pkg::SEL_SIGNATURE
    && $past(adr, 3) == epv_pkg::SIG_ADDR_0
    |-> programDataBusOut == SIG_BYTE_0) else $error("bad signature");
  lock_rank_a: assert property (
    !(verifyInhibit && !programInhibit)
    && !(externalExecInhibit && !verifyInhibit)) else $error("lock rank");
  verify_block_a: assert property (
    verifyInhibit && $past(verifyInhibit, 4)
    && $past(sel, 3) == epv_pkg::SEL_VERIFY
    |-> programDataBusOeN) else $error("verify not blocked");
  erase_clear_a: assert property (
    eraseRequest [*6] |-> !programInhibit && !verifyInhibit
    && !externalExecInhibit) else $error("erase kept locks");
  lock_set_a: assert property (
    $fell(latchProgramStrobeN) && resetPin && !programStoreEnableN
    && supplyAtProgramVoltage && sel == epv_pkg::SEL_LOCK1 && !eraseRequest
    |-> ##[1:8] programInhibit) else $error("lock bit not set");
endmodule
`default_nettype wire

/* File: epv_sync.sv */
// Two-flop synchroniser for a bundle of asynchronous pin levels
`timescale 1ns/1ps
`default_nettype none
module epv_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             sys_clk,
  input  wire logic             reset,
  input  wire logic [WIDTH-1:0] asyncIn,
  output logic      [WIDTH-1:0] syncOut
);

  typedef struct packed {
    logic [WIDTH-1:0] stageOne;
    logic [WIDTH-1:0] stageTwo;
  } epv_sync_state_t;

  epv_sync_state_t state;
  epv_sync_state_t next_state;

  // Stage one feeds stage two only; nothing else may look at it
  always_comb begin
    next_state.stageOne = asyncIn;
    next_state.stageTwo = state.stageOne;
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign syncOut = state.stageTwo;

endmodule
`default_nettype wire
